// [cbsp_pkg.sv]
package cbsp_pkg;
  localparam logic [11:0] SOCK_CTRL_OFF  = 12'h010;
  localparam logic [11:0] SOCK_PM_OFF    = 12'h020;
  localparam logic [11:0] IRQ_STAT_OFF   = 12'h030;
  localparam logic [11:0] IRQ_CLR_OFF    = 12'h034;
  localparam logic [11:0] IRQ_EN_OFF     = 12'h038;
  localparam logic [11:0] FORCE_OFF      = 12'h03c;
  localparam logic [11:0] CARD_OFF       = 12'h040;
  localparam int          CTRL_ONE_BIT   = 10;
  localparam int          FOLLOW_BIT     = 7;
  localparam int          CARD_LSB       = 4;
  localparam int          PROG_LSB       = 0;
  localparam int          ACC_BIT        = 25;
  localparam int          MODE_BIT       = 24;
  localparam int          CLKEN_BIT      = 16;
  localparam int          SLOW_BIT       = 0;
  localparam int          RETEST_BIT     = 14;
  localparam int          FORCE_LSB      = 10;
  localparam int          PME_EN_BIT     = 0;
  localparam int          N_EVT          = 3;
  localparam logic [2:0]  SUP_OFF        = 3'h0;
  localparam logic [2:0]  SUP_12V        = 3'h1;
  localparam logic [2:0]  SUP_5V         = 3'h2;
  localparam logic [2:0]  SUP_3V3        = 3'h3;
  localparam logic [2:0]  SUP_XX         = 3'h4;
  localparam logic [2:0]  SUP_YY         = 3'h5;
  localparam int          SLOW_DIV       = 16;
  // accepted-voltage mask order from card: {YY, XX, 3V3, 5V}
  typedef struct packed {
    logic [2:0] card_code;
    logic [2:0] prog_code;
  } cbsp_supply_t;
  typedef enum logic [1:0] {
    CK_RUN  = 2'b00,
    CK_STOP = 2'b01,
    CK_SLOW = 2'b11
  } cbsp_ck_t;
endpackage

// [cbsp_top.sv]
`timescale 1ns/10ps
module cbsp_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        GLOBAL_RESET_IN_I,
  input  wire logic        HOST_BUS_RESET_IN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [3:0]  CARD_VOLT_OK_I,
  input  wire logic        CARD_IDLE_I,
  input  wire logic        CARD_ACCESS_I,
  input  wire logic        HOST_CLKRUN_STOP_I,
  output cbsp_pkg::cbsp_supply_t SUPPLY_O,
  output logic             CARD_CLK_STOP_O,
  output logic             CARD_CLK_SLOW_O,
  output logic             IRQ_O
);
  // pin inputs: three-flop synchronisers, change seen when stages 2 and 3 agree
  localparam int NS = 6;
  logic [NS-1:0] s1_r, s2_r, s3_r, sv_r;
  logic [NS-1:0] pin_raw;
  assign pin_raw = {GLOBAL_RESET_IN_I, HOST_BUS_RESET_IN_I, CARD_IDLE_I,
                    CARD_ACCESS_I, HOST_CLKRUN_STOP_I, 1'b0};
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          sv_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pin_raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            sv_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate
  logic global_reset_in, host_bus_reset_in, idle, acc, host_stop, acc_d_r;
  assign global_reset_in      = sv_r[5];
  assign host_bus_reset_in      = sv_r[4];
  assign idle      = sv_r[3];
  assign acc       = sv_r[2];
  assign host_stop = sv_r[1];

  // card voltage sense is a pin bundle too: same three-flop filter
  localparam int NV = 4;
  logic [NV-1:0] volt_s1_r;
  logic [NV-1:0] volt_s2_r;
  logic [NV-1:0] volt_s3_r;
  logic [NV-1:0] volt_sv_r;
  logic [NV-1:0] volt_r;
  genvar v;
  generate
    for (v = 0; v < NV; v++) begin : g_volt_sync
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          volt_s1_r[v] <= 1'b0;
          volt_s2_r[v] <= 1'b0;
          volt_s3_r[v] <= 1'b0;
          volt_sv_r[v] <= 1'b0;
        end else begin
          volt_s1_r[v] <= CARD_VOLT_OK_I[v];
          volt_s2_r[v] <= volt_s1_r[v];
          volt_s3_r[v] <= volt_s2_r[v];
          if (volt_s2_r[v] == volt_s3_r[v]) begin
            volt_sv_r[v] <= volt_s3_r[v];
          end
        end
      end
    end
  endgenerate

  // registers
  localparam int N_EVT_W = cbsp_pkg::N_EVT;
  logic       follow_r;
  logic [2:0] card_req_r, prog_req_r;
  logic       clken_r, slow_r, acc_flag_r, pme_en_r, pwr_ctl_en_r;
  logic       clk_mode_r;
  logic [N_EVT_W-1:0] ist_r, ien_r;
  cbsp_pkg::cbsp_ck_t ck_r, ck_nxt;

  logic wr, rd;
  logic hit_ctrl, hit_pm, hit_st, hit_clr, hit_en, hit_frc, hit_card;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign rd = PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O;

  // address decode: one register per offset, unknown offsets hit none
  always_comb begin
    hit_ctrl = 1'b0;
    hit_pm   = 1'b0;
    hit_st   = 1'b0;
    hit_clr  = 1'b0;
    hit_en   = 1'b0;
    hit_frc  = 1'b0;
    hit_card = 1'b0;
    if (PADDR_I == cbsp_pkg::SOCK_CTRL_OFF) begin
      hit_ctrl = 1'b1;
    end else if (PADDR_I == cbsp_pkg::SOCK_PM_OFF) begin
      hit_pm = 1'b1;
    end else if (PADDR_I == cbsp_pkg::IRQ_STAT_OFF) begin
      hit_st = 1'b1;
    end else if (PADDR_I == cbsp_pkg::IRQ_CLR_OFF) begin
      hit_clr = 1'b1;
    end else if (PADDR_I == cbsp_pkg::IRQ_EN_OFF) begin
      hit_en = 1'b1;
    end else if (PADDR_I == cbsp_pkg::FORCE_OFF) begin
      hit_frc = 1'b1;
    end else if (PADDR_I == cbsp_pkg::CARD_OFF) begin
      hit_card = 1'b1;
    end
  end

  // one wait state: ready in the second cycle of the access phase
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
    end
  end

  // supply fields: context bits, kept across host reset while PME on
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in || (host_bus_reset_in && !pme_en_r)) begin
      card_req_r <= cbsp_pkg::SUP_OFF;
      prog_req_r <= cbsp_pkg::SUP_OFF;
    end else if (wr && hit_ctrl) begin
      card_req_r <= PWDATA_I[cbsp_pkg::CARD_LSB +: 3];
      prog_req_r <= PWDATA_I[cbsp_pkg::PROG_LSB +: 3];
    end
  end

  // host-reset cleared controls
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in || host_bus_reset_in) begin
      follow_r <= 1'b0;
    end else if (wr && hit_ctrl) begin
      follow_r <= PWDATA_I[cbsp_pkg::FOLLOW_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in || host_bus_reset_in) begin
      clken_r <= 1'b0;
      slow_r  <= 1'b0;
    end else if (wr && hit_pm) begin
      clken_r <= PWDATA_I[cbsp_pkg::CLKEN_BIT];
      slow_r  <= PWDATA_I[cbsp_pkg::SLOW_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in || host_bus_reset_in) begin
      ien_r <= '0;
    end else if (wr && hit_en) begin
      ien_r <= PWDATA_I[N_EVT_W-1:0];
    end
  end

  // pme enable must outlive host reset, or that reset would wipe the
  // very context bits it is meant to protect
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in) begin
      pme_en_r <= 1'b0;
    end else if (wr && hit_card) begin
      pme_en_r <= PWDATA_I[cbsp_pkg::PME_EN_BIT];
    end
  end

  // card voltage sense tracked while power control on, reloaded on retest; force parks power control
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in || host_bus_reset_in) begin
      pwr_ctl_en_r <= 1'b1;
      volt_r       <= '0;
    end else begin
      if (wr && hit_frc && PWDATA_I[cbsp_pkg::RETEST_BIT]) begin
        pwr_ctl_en_r <= 1'b1;
        volt_r       <= volt_sv_r;
      end else if (wr && hit_frc && |PWDATA_I[cbsp_pkg::FORCE_LSB +: 4]) begin
        pwr_ctl_en_r <= 1'b0;
      end else if (pwr_ctl_en_r) begin
        volt_r <= volt_sv_r;
      end
    end
  end

  // access flag: set wins over read clear, only global reset clears
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in) begin
      acc_flag_r <= 1'b0;
      acc_d_r    <= 1'b0;
    end else begin
      acc_d_r <= acc;
      if (acc && !acc_d_r) begin
        acc_flag_r <= 1'b1;
      end else if (rd && hit_pm) begin
        acc_flag_r <= 1'b0;
      end
    end
  end

  // clock stop/slow control
  logic allow;
  assign allow = clken_r && idle && (follow_r ? host_stop : 1'b1);
  // stop and slow never swap directly: always back through run first
  always_comb begin
    ck_nxt = ck_r;
    case (ck_r)
      cbsp_pkg::CK_RUN: begin
        if (allow) begin
          ck_nxt = slow_r ? cbsp_pkg::CK_SLOW
                          : cbsp_pkg::CK_STOP;
        end
      end
      cbsp_pkg::CK_STOP: begin
        if (!allow || slow_r) begin
          ck_nxt = cbsp_pkg::CK_RUN;
        end
      end
      cbsp_pkg::CK_SLOW: begin
        if (!allow || !slow_r) begin
          ck_nxt = cbsp_pkg::CK_RUN;
        end
      end
      default: ck_nxt = cbsp_pkg::CK_RUN;
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in) begin
      ck_r            <= cbsp_pkg::CK_RUN;
      CARD_CLK_STOP_O <= 1'b0;
      CARD_CLK_SLOW_O <= 1'b0;
    end else begin
      ck_r            <= ck_nxt;
      CARD_CLK_STOP_O <= ck_nxt == cbsp_pkg::CK_STOP;
      CARD_CLK_SLOW_O <= ck_nxt == cbsp_pkg::CK_SLOW;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in) begin
      clk_mode_r <= 1'b0;
    end else begin
      clk_mode_r <= ck_nxt != cbsp_pkg::CK_RUN;
    end
  end

  // power switch drive: only legal, card-accepted codes reach the pins
  function automatic logic [2:0] legal(input logic [2:0] c,
                                       input logic       prog,
                                       input logic [3:0] ok);
    logic [2:0] r;
    r = cbsp_pkg::SUP_OFF;
    case (c)
      cbsp_pkg::SUP_12V: r = prog ? c : cbsp_pkg::SUP_OFF;
      cbsp_pkg::SUP_5V:  r = ok[0] ? c : cbsp_pkg::SUP_OFF;
      cbsp_pkg::SUP_3V3: r = ok[1] ? c : cbsp_pkg::SUP_OFF;
      cbsp_pkg::SUP_XX:  r = ok[2] ? c : cbsp_pkg::SUP_OFF;
      cbsp_pkg::SUP_YY:  r = ok[3] ? c : cbsp_pkg::SUP_OFF;
      default:           r = cbsp_pkg::SUP_OFF;
    endcase
    return r;
  endfunction

  logic [2:0] card_drv;
  logic [2:0] prog_drv;
  assign card_drv = legal(card_req_r, 1'b0, volt_r);
  // programming rail only alongside a live card rail
  assign prog_drv = (card_drv == cbsp_pkg::SUP_OFF) ? cbsp_pkg::SUP_OFF :
                    legal(prog_req_r, 1'b1, volt_r);
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SUPPLY_O <= '0;
    end else if (!pwr_ctl_en_r) begin
      SUPPLY_O <= '0;
    end else begin
      SUPPLY_O.card_code <= card_drv;
      SUPPLY_O.prog_code <= prog_drv;
    end
  end

  // interrupts: access, clock mode change, power control lost
  logic [N_EVT_W-1:0] ev;
  logic               ev_acc;
  logic               ev_mode;
  logic               ev_pwr;
  logic               pwr_d_r;
  logic               mode_d_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pwr_d_r  <= 1'b1;
      mode_d_r <= 1'b0;
    end else begin
      pwr_d_r  <= pwr_ctl_en_r;
      mode_d_r <= clk_mode_r;
    end
  end
  assign ev_acc  = acc && !acc_d_r;
  assign ev_mode = clk_mode_r != mode_d_r;
  assign ev_pwr  = pwr_d_r && !pwr_ctl_en_r;
  assign ev      = {ev_pwr, ev_mode, ev_acc};
  always_ff @(posedge CLK_I) begin
    if (RST_I || global_reset_in) begin
      ist_r <= '0;
    end else begin
      ist_r <= ev | (ist_r & ~((wr && hit_clr) ? PWDATA_I[N_EVT_W-1:0] : '0));
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(ist_r & ien_r);
    end
  end

  // read mux
  logic [31:0] rdat;
  always_comb begin
    rdat = '0;
    if (hit_ctrl) begin
      rdat[cbsp_pkg::CTRL_ONE_BIT]         = 1'b1;
      rdat[cbsp_pkg::FOLLOW_BIT]           = follow_r;
      rdat[cbsp_pkg::CARD_LSB +: 3]        = card_req_r;
      rdat[cbsp_pkg::PROG_LSB +: 3]        = prog_req_r;
    end else if (hit_pm) begin
      rdat[cbsp_pkg::ACC_BIT]   = acc_flag_r;
      rdat[cbsp_pkg::MODE_BIT]  = clk_mode_r;
      rdat[cbsp_pkg::CLKEN_BIT] = clken_r;
      rdat[cbsp_pkg::SLOW_BIT]  = slow_r;
    end else if (hit_st) begin
      rdat[N_EVT_W-1:0] = ist_r;
    end else if (hit_en) begin
      rdat[N_EVT_W-1:0] = ien_r;
    end else if (hit_card) begin
      rdat[cbsp_pkg::PME_EN_BIT] = pme_en_r;
      rdat[cbsp_pkg::FORCE_LSB +: 4] = volt_r;
      rdat[cbsp_pkg::RETEST_BIT] = pwr_ctl_en_r;
    end
  end
  logic known;
  assign known = hit_ctrl | hit_pm | hit_st | hit_clr | hit_en | hit_frc
                 | hit_card;
  // read data only while a read is in its access phase, zero otherwise
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PRDATA_O <= '0;
    end else begin
      PRDATA_O <= (PSEL_I && PENABLE_I && !PWRITE_I) ? rdat : '0;
    end
  end

  // error rides with the ready of the same transfer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !known;
    end
  end
endmodule

// [cbsp_asserts.sv]
`timescale 1ns/10ps
module cbsp_asserts (
  input wire logic                   CLK_I,
  input wire logic                   RST_I,
  input wire logic                   PSEL_I,
  input wire logic                   PENABLE_I,
  input wire logic                   PWRITE_I,
  input wire logic [11:0]            PADDR_I,
  input wire logic [31:0]            PWDATA_I,
  input wire logic [31:0]            PRDATA_O,
  input wire logic                   PREADY_O,
  input wire logic                   PSLVERR_O,
  input wire cbsp_pkg::cbsp_supply_t SUPPLY_O,
  input wire logic                   CARD_CLK_STOP_O,
  input wire logic                   CARD_CLK_SLOW_O
);
  logic       rd_ok;
  logic       en_r;
  logic       sel_r;
  logic [3:0] age_r;
  assign rd_ok = PSEL_I & PENABLE_I & PREADY_O & ~PSLVERR_O & ~PWRITE_I;
  // mirror of idle clock bits; age hides synchroniser and mode latency
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      en_r  <= 1'h0;
      sel_r <= 1'h0;
      age_r <= 4'h0;
    end else if (PSEL_I & PENABLE_I & PREADY_O & PWRITE_I &
                 PADDR_I == cbsp_pkg::SOCK_PM_OFF) begin
      en_r  <= PWDATA_I[16];
      sel_r <= PWDATA_I[0];
      age_r <= 4'h0;
    end else if (age_r != 4'hf) begin
      age_r <= age_r + 4'h1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_card_rsvd_off: assert property (SUPPLY_O.card_code inside {3'h0,
    [3'h2:3'h5]}) else $error("card rail driven with reserved code");
  a_prog_rsvd_off: assert property (SUPPLY_O.prog_code <= 3'h5)
    else $error("program rail driven with reserved code");
  a_prog_needs_card: assert property (SUPPLY_O.prog_code != 3'h0 |->
    SUPPLY_O.card_code != 3'h0) else $error("program rail without card");
  a_stop_slow_excl: assert property (!(CARD_CLK_STOP_O && CARD_CLK_SLOW_O))
    else $error("clock stopped and slowed at once");
  a_idle_ctl_off: assert property (age_r > 4'h7 && !en_r |->
    !CARD_CLK_STOP_O && !CARD_CLK_SLOW_O) else $error("idle control off");
  a_stop_select: assert property (age_r > 4'h7 && CARD_CLK_STOP_O |-> !sel_r)
    else $error("clock stopped while slow selected");
  a_slow_select: assert property (age_r > 4'h7 && CARD_CLK_SLOW_O |-> sel_r)
    else $error("clock slowed while stop selected");
  a_ctrl_fixed: assert property (rd_ok && PADDR_I == cbsp_pkg::SOCK_CTRL_OFF
    |-> PRDATA_O[31:8] == 24'h4 && !PRDATA_O[3])
    else $error("control fixed bits wrong");
  a_pm_rsvd_zero: assert property (rd_ok && PADDR_I == cbsp_pkg::SOCK_PM_OFF
    |-> PRDATA_O[31:26] == 6'h0 && PRDATA_O[23:17] == 7'h0 &&
    PRDATA_O[15:1] == 15'h0) else $error("pm reserved bits set");
  cover property (SUPPLY_O.card_code == cbsp_pkg::SUP_3V3);
  cover property (CARD_CLK_SLOW_O);
  cover property (PREADY_O && PSLVERR_O);
endmodule
bind cbsp_top cbsp_asserts u_chk (.CLK_I(CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SUPPLY_O(SUPPLY_O),
  .CARD_CLK_STOP_O(CARD_CLK_STOP_O), .CARD_CLK_SLOW_O(CARD_CLK_SLOW_O));

// [cbsp_card_model.sv]
`timescale 1ns/10ps
module cbsp_card_model #(parameter logic [3:0] OK = 4'h3) (
  input  wire logic       clk_i,
  input  wire logic       req_i,
  input  wire logic [2:0] sup_i,
  output logic [3:0]      ok_o,
  output logic            idle_o,
  output logic            acc_o
);
  logic [2:0] busy_r = 3'h0;
  // accepts 5 V and 3.3 V only, so other rails must stay off
  assign ok_o   = OK;
  assign idle_o = (busy_r == 3'h0);
  // access held three cycles: a one-cycle blip dies in the pin filter
  assign acc_o  = (busy_r >= 3'h5);
  // an unpowered card cannot start a transaction
  always_ff @(posedge clk_i) begin
    if (req_i & (sup_i != 3'h0)) busy_r <= 3'h7;
    else if (busy_r != 3'h0) busy_r <= busy_r - 3'h1;
  end
endmodule

// [cardbus_socket_power_clock_ctrl_tb.sv]
`timescale 1ns/10ps
module cardbus_socket_power_clock_ctrl_tb;
  logic                   clk = 0, rst = 1, global_reset_in = 0, hrst = 0;
  logic                   psel = 0, pen = 0, pwr = 0, hstop = 0, areq = 0;
  logic [11:0]            padr = '0;
  logic [31:0]            pwd = '0, prd, q;
  logic                   prdy, perr, stp, slw, irq, idle, acc, e;
  logic [3:0]             ok;
  cbsp_pkg::cbsp_supply_t sup;
  int                     fails = 0, check_count = 0;
  always #12.5 clk = ~clk;
  cbsp_top DUT (.CLK_I(clk), .RST_I(rst), .GLOBAL_RESET_IN_I(global_reset_in),
    .HOST_BUS_RESET_IN_I(hrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .CARD_VOLT_OK_I(ok),
    .CARD_IDLE_I(idle), .CARD_ACCESS_I(acc), .HOST_CLKRUN_STOP_I(hstop),
    .SUPPLY_O(sup), .CARD_CLK_STOP_O(stp), .CARD_CLK_SLOW_O(slw),
    .IRQ_O(irq));
  cbsp_card_model card (.clk_i(clk), .req_i(areq), .sup_i(sup.card_code),
    .ok_o(ok), .idle_o(idle), .acc_o(acc));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'h1 && n < 20);
    if (prdy !== 1'h1) begin
      fails++;
      end_of_test;
    end
    q = prd;
    e = perr;
    psel <= 1'h0;
    pen  <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
    bus(1'h0, a, 32'h0);
    chk(q & m, x);
  endtask
  function automatic logic [31:0] obs(input int s);
    return s == 0 ? {26'h0, sup} : s == 1 ? {30'h0, stp, slw} : {31'h0, irq};
  endfunction
  // outputs settle through synchronisers, so poll with a bound
  task automatic wt(input int s, input logic [31:0] x);
    for (int n = 0; n < 40 && obs(s) !== x; n++) @(posedge clk);
    chk(obs(s), x);
    if (obs(s) !== x) end_of_test;
  endtask
  task automatic pin(input logic g);
    if (g) global_reset_in <= 1'h1;
    else hrst <= 1'h1;
    repeat (6) @(posedge clk);
    global_reset_in <= 1'h0;
    hrst <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic access;
    areq <= 1'h1;
    @(posedge clk);
    areq <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    bus(1'h1, 12'h03c, 32'h4000);
    rd(12'h010, '1, 32'h400);
    rd(12'h020, '1, 32'h0);
    bus(1'h1, 12'h010, '1);
    rd(12'h010, '1, 32'h4f7);
    wt(0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, 12'h010, 32'(i * 17));
      wt(0, (i == 2 || i == 3) ? 32'(i * 9) : 32'h0);
    end
    bus(1'h1, 12'h010, 32'h22);
    wt(0, 32'h12);
    bus(1'h1, 12'h03c, 32'h400);
    wt(0, 32'h0);
    bus(1'h1, 12'h03c, 32'h4000);
    wt(0, 32'h12);
    pin(1'h0);
    wt(0, 32'h0);
    rd(12'h010, '1, 32'h400);
    bus(1'h1, 12'h040, 32'h1);
    bus(1'h1, 12'h010, 32'h33);
    wt(0, 32'h1b);
    bus(1'h1, 12'h038, 32'h1);
    access;
    wt(2, 32'h1);
    pin(1'h0);
    wt(0, 32'h1b);
    rd(12'h010, 32'h77, 32'h33);
    rd(12'h020, 32'h2000000, 32'h2000000);
    rd(12'h020, 32'h2000000, 32'h0);
    rd(12'h030, 32'h1, 32'h1);
    bus(1'h1, 12'h034, 32'h7);
    wt(2, 32'h0);
    bus(1'h1, 12'h038, 32'h0);
    access;
    chk({31'h0, irq}, 32'h0);
    rd(12'h030, 32'h1, 32'h1);
    hstop <= 1'h1;
    bus(1'h1, 12'h020, 32'h10000);
    wt(1, 32'h2);
    rd(12'h020, 32'h1000000, 32'h1000000);
    bus(1'h1, 12'h010, 32'hb3);
    hstop <= 1'h0;
    wt(1, 32'h0);
    hstop <= 1'h1;
    wt(1, 32'h2);
    bus(1'h1, 12'h010, 32'h33);
    bus(1'h1, 12'h020, 32'h10001);
    wt(1, 32'h1);
    bus(1'h1, 12'h020, 32'h1);
    wt(1, 32'h0);
    rd(12'h020, 32'hffffff, 32'h1);
    bus(1'h0, 12'h044, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    pin(1'h1);
    wt(0, 32'h0);
    rd(12'h020, 32'h3000000, 32'h0);
    end_of_test;
  end
endmodule
